// ---- rtl/irt_pkg.sv ----
package irt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_SHARED = 4'h1;
  localparam logic [3:0] IDX_LONG = 4'h2;
  localparam logic [3:0] IDX_RLD_LO = 4'h6;
  localparam logic [3:0] IDX_RLD_HI = 4'h7;
  localparam logic [3:0] IDX_CAP_LO = 4'h8;
  localparam logic [3:0] IDX_CAP_HI = 4'h9;
  // Shared control bit positions
  localparam int SC_MODE = 7;
  localparam int SC_ROUTE = 6;
  localparam int SC_SEL_LO = 4;
  localparam int SC_SUB_LO = 2;
  localparam int SC_INIT_S = 1;
  localparam int SC_INIT_L = 0;
  // Long timer control bit positions
  localparam int LC_EN = 7;
  localparam int LC_SINGLE = 6;
  localparam int LC_TO = 5;
  localparam int LC_CLK_LO = 3;
  localparam int LC_CAPM = 2;
  localparam int LC_TOM = 1;
  localparam int LC_PIN = 0;
  // Reset values, and the demodulation reload value
  localparam logic [7:0] SHARED_RST = 8'h00;
  localparam logic [7:0] LONG_RST = 8'h00;
  localparam logic [15:0] RLD_RST = 16'h0000;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [15:0] DEMOD_RELOAD = 16'hFFFF;
  // Field codes
  localparam logic [1:0] LOG_AND = 2'h0;
  localparam logic [1:0] LOG_OR = 2'h1;
  localparam logic [1:0] LOG_NOR = 2'h2;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_PP = 2'h1;
  localparam logic [1:0] SUB_LOW = 2'h2;
  localparam logic [1:0] SUB_HIGH = 2'h3;
  localparam logic [1:0] FILT_4 = 2'h1;
  localparam logic [1:0] FILT_8 = 2'h2;
  // Glitch filter widths in system clock cycles
  localparam logic [3:0] FILT_CYC_NONE = 4'h1;
  localparam logic [3:0] FILT_CYC_4 = 4'h4;
  localparam logic [3:0] FILT_CYC_8 = 4'h8;
  typedef enum logic [1:0] {LT_IDLE, LT_ARM, LT_RUN} irt_lt_state_t;
endpackage

// ---- rtl/irt_edge_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface irt_edge_if;
  logic alt_sel;
  logic [1:0] edge_sel;
  logic [1:0] filt_sel;
  logic rise;
  logic fall;
  modport ctl (output alt_sel, output edge_sel, output filt_sel, input rise, input fall);
  modport det (input alt_sel, input edge_sel, input filt_sel, output rise, output fall);
endinterface
`default_nettype wire

// ---- rtl/irt_edge_detect.sv ----
`timescale 1ns/100ps
`default_nettype none
module irt_edge_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic first_input_pin,
  input wire logic alternate_input_pin,
  irt_edge_if.det eif
);
  logic filt_q;
  logic filt_d;
  logic [3:0] run_q;
  logic [3:0] run_d;
  logic rise_q;
  logic rise_d;
  logic fall_q;
  logic fall_d;
  logic raw;
  logic [3:0] need;

  always_comb
  begin
    raw = eif.alt_sel ? alternate_input_pin : first_input_pin;
    case (eif.filt_sel)
      irt_pkg::FILT_4: need = irt_pkg::FILT_CYC_4;
      irt_pkg::FILT_8: need = irt_pkg::FILT_CYC_8;
      default: need = irt_pkg::FILT_CYC_NONE;
    endcase
    filt_d = filt_q;
    run_d = 4'h0;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (raw != filt_q)
    begin
      // Level must disagree for the full width before it is accepted
      if (run_q + 4'h1 >= need)
      begin
        filt_d = raw;
        rise_d = raw && (eif.edge_sel == irt_pkg::EDGE_RISE ||
                         eif.edge_sel == irt_pkg::EDGE_BOTH);
        fall_d = !raw && (eif.edge_sel == irt_pkg::EDGE_FALL ||
                          eif.edge_sel == irt_pkg::EDGE_BOTH);
      end
      else
      begin
        run_d = run_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      filt_q <= 1'b0;
      run_q <= 4'h0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      filt_q <= filt_d;
      run_q <= run_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign eif.rise = rise_q;
  assign eif.fall = fall_q;
endmodule
`default_nettype wire

// ---- rtl/irt_timer_ctrl.sv ----
// Functional notes
// - Shared bit 7: transmit or demodulation
// - Transmit bit 6: route combined output pin
// - Demod bit 6: choose demodulator input pin
// - Transmit bits 5:4: AND/OR/NOR/NAND combine
// - Demod bits 5:4: falling, rising, both edges
// - Transmit bits 3:2: normal or ping-pong
// - Codes 10/11 force long output low/high
// - Demod bits 3:2: glitch filter 4/8 cycles
// - Short timer initial level, inverse when idle
// - Long timer initial level, inverse when idle
// - Demod bit 1: sticky rising flag, W1C
// - Demod bit 0: sticky falling flag, W1C
// - Long bit 7: run status, start/stop
// - Transmit long bit 6: reload or stop
// - Demod long bit 6: every or first edge
// - Long bit 5: sticky time-out flag, W1C
// - Long bits 4:3: prescale 1/2/4/8
// - Long bit 2: capture interrupt mask
// - Long bit 1: time-out interrupt mask
// - Long bit 0: route long timer pin
// - Capture complemented count on later edge
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module irt_timer_ctrl #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic first_input_pin,
  input wire logic alternate_input_pin,
  input wire logic short_timer_running,
  input wire logic short_timer_level,
  input wire logic short_timer_done,
  input wire logic port_combined_data,
  input wire logic port_long_data,
  output logic short_timer_start,
  output logic short_timer_output,
  output logic long_timer_output,
  output logic combined_output_pin,
  output logic long_timer_pin,
  output logic capture_irq,
  output logic timeout_irq
);
  irt_edge_if eif ();

  logic [7:0] shared_q, shared_d;
  logic [7:0] long_q, long_d;
  logic rise_flag_q, rise_flag_d;
  logic fall_flag_q, fall_flag_d;
  logic to_flag_q, to_flag_d;
  logic [CNT_W-1:0] rld_q, rld_d;
  logic [CNT_W-1:0] cap_q, cap_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  irt_pkg::irt_lt_state_t lt_q, lt_d;
  logic lout_q, lout_d;
  logic [2:0] div_q, div_d;
  logic wr_pend_q, wr_pend_d;
  logic [3:0] wr_idx_q, wr_idx_d;
  logic [31:0] rdata_q, rdata_d;
  logic sout_q, sout_d;
  logic loutp_q, loutp_d;
  logic comb_q, comb_d;
  logic lpin_q, lpin_d;
  logic start_q, start_d;
  logic capirq_q, capirq_d;
  logic toirq_q, toirq_d;

  logic demod;
  logic [1:0] sub;
  logic tick;
  logic term;
  logic edge_any;
  logic cap_ev;
  logic to_ev;
  logic start_long;
  logic [7:0] rd_byte;
  logic [7:0] wb;
  logic combo;

  assign eif.alt_sel = shared_q[irt_pkg::SC_ROUTE];
  assign eif.edge_sel = shared_q[irt_pkg::SC_SEL_LO +: 2];
  assign eif.filt_sel = shared_q[irt_pkg::SC_SUB_LO +: 2];

  irt_edge_detect u_edge (
    .clk(clk),
    .rst(rst),
    .first_input_pin(first_input_pin),
    .alternate_input_pin(alternate_input_pin),
    .eif(eif)
  );

  always_comb
  begin
    demod = shared_q[irt_pkg::SC_MODE];
    sub = shared_q[irt_pkg::SC_SUB_LO +: 2];
    wb = hwdata[7:0];
    edge_any = demod && (eif.rise || eif.fall);
    div_d = div_q + 3'h1;
    case (long_q[irt_pkg::LC_CLK_LO +: 2])
      2'h0: tick = 1'b1;
      2'h1: tick = div_q[0];
      2'h2: tick = &div_q[1:0];
      default: tick = &div_q;
    endcase
    term = tick && cnt_q == {{(CNT_W-1){1'b0}}, 1'b1};

    shared_d = shared_q;
    long_d = long_q;
    rise_flag_d = rise_flag_q;
    fall_flag_d = fall_flag_q;
    to_flag_d = to_flag_q;
    rld_d = rld_q;
    cap_d = cap_q;
    cnt_d = cnt_q;
    lt_d = lt_q;
    lout_d = lout_q;
    cap_ev = 1'b0;
    to_ev = 1'b0;
    start_d = 1'b0;
    start_long = 1'b0;

    // Register writes land in the data phase
    if (wr_pend_q)
    begin
      case (wr_idx_q)
        irt_pkg::IDX_SHARED:
        begin
          if (demod)
          begin
            shared_d[7:2] = wb[7:2];
            if (wb[irt_pkg::SC_INIT_S])
              rise_flag_d = 1'b0;
            if (wb[irt_pkg::SC_INIT_L])
              fall_flag_d = 1'b0;
          end
          else
          begin
            shared_d = wb;
          end
        end
        irt_pkg::IDX_LONG:
        begin
          long_d = wb;
          long_d[irt_pkg::LC_EN] = 1'b0;
          long_d[irt_pkg::LC_TO] = 1'b0;
          if (wb[irt_pkg::LC_TO])
            to_flag_d = 1'b0;
          if (!wb[irt_pkg::LC_EN])
            lt_d = irt_pkg::LT_IDLE;
          else if (lt_q == irt_pkg::LT_IDLE)
            start_long = 1'b1;
          else if (demod && wb[irt_pkg::LC_SINGLE] && !long_q[irt_pkg::LC_SINGLE])
            lt_d = irt_pkg::LT_ARM;
        end
        irt_pkg::IDX_RLD_LO: rld_d[7:0] = wb;
        irt_pkg::IDX_RLD_HI: rld_d[CNT_W-1:8] = wb[CNT_W-9:0];
        default: ;
      endcase
    end

    // Ping-pong: short timer terminal count hands over to the long timer
    if (!demod && sub == irt_pkg::SUB_PP && short_timer_done && lt_q == irt_pkg::LT_IDLE)
      start_long = 1'b1;

    case (lt_q)
      irt_pkg::LT_IDLE: ;
      irt_pkg::LT_ARM:
      begin
        if (edge_any)
        begin
          cap_d = ~cnt_q;
          cap_ev = 1'b1;
          cnt_d = rld_q;
          lt_d = irt_pkg::LT_RUN;
        end
      end
      irt_pkg::LT_RUN:
      begin
        if (edge_any && !long_q[irt_pkg::LC_SINGLE])
        begin
          cap_d = ~cnt_q;
          cap_ev = 1'b1;
          cnt_d = irt_pkg::DEMOD_RELOAD;
        end
        else if (demod && long_q[irt_pkg::LC_SINGLE] && short_timer_done)
        begin
          cap_d = ~cnt_q;
          cap_ev = 1'b1;
        end
        else if (tick)
        begin
          cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
          if (term)
          begin
            to_ev = 1'b1;
            if (!demod)
            begin
              lout_d = ~lout_q;
              if (sub == irt_pkg::SUB_PP)
              begin
                lt_d = irt_pkg::LT_IDLE;
                start_d = 1'b1;
              end
              else if (long_q[irt_pkg::LC_SINGLE])
                lt_d = irt_pkg::LT_IDLE;
              else
                cnt_d = rld_q;
            end
          end
        end
      end
      default: lt_d = irt_pkg::LT_IDLE;
    endcase

    if (start_long && !(wr_pend_q && wr_idx_q == irt_pkg::IDX_LONG
        && !wb[irt_pkg::LC_EN]))
    begin
      cnt_d = rld_q;
      lout_d = shared_q[irt_pkg::SC_INIT_L];
      lt_d = demod ? irt_pkg::LT_ARM : irt_pkg::LT_RUN;
    end

    // Hardware sets are applied last so they win over a clear
    if (eif.rise && demod)
      rise_flag_d = 1'b1;
    if (eif.fall && demod)
      fall_flag_d = 1'b1;
    if (to_ev)
      to_flag_d = 1'b1;
    capirq_d = cap_ev && long_q[irt_pkg::LC_CAPM];
    toirq_d = to_ev && long_q[irt_pkg::LC_TOM];

    // Output levels
    sout_d = short_timer_running ? short_timer_level
                                 : ~shared_q[irt_pkg::SC_INIT_S];
    if (!demod && sub == irt_pkg::SUB_LOW)
      loutp_d = 1'b0;
    else if (!demod && sub == irt_pkg::SUB_HIGH)
      loutp_d = 1'b1;
    else if (lt_q != irt_pkg::LT_IDLE)
      loutp_d = lout_q;
    else
      loutp_d = ~shared_q[irt_pkg::SC_INIT_L];
    case (shared_q[irt_pkg::SC_SEL_LO +: 2])
      irt_pkg::LOG_AND: combo = sout_q & loutp_q;
      irt_pkg::LOG_OR: combo = sout_q | loutp_q;
      irt_pkg::LOG_NOR: combo = ~(sout_q | loutp_q);
      default: combo = ~(sout_q & loutp_q);
    endcase
    comb_d = (!demod && shared_q[irt_pkg::SC_ROUTE]) ? combo : port_combined_data;
    lpin_d = long_q[irt_pkg::LC_PIN] ? loutp_q : port_long_data;

    // Bus slave: zero wait states, read data registered in address phase
    wr_pend_d = hsel && htrans[1] && hready && hwrite && haddr[7:6] == 2'h0;
    wr_idx_d = haddr[5:2];
    case (haddr[5:2])
      irt_pkg::IDX_SHARED:
        rd_byte = demod ? {shared_q[7:2], rise_flag_q, fall_flag_q} : shared_q;
      irt_pkg::IDX_LONG:
      begin
        rd_byte = long_q;
        rd_byte[irt_pkg::LC_EN] = lt_q != irt_pkg::LT_IDLE;
        rd_byte[irt_pkg::LC_TO] = to_flag_q;
      end
      irt_pkg::IDX_RLD_LO: rd_byte = rld_q[7:0];
      irt_pkg::IDX_RLD_HI: rd_byte = rld_q[CNT_W-1:8];
      irt_pkg::IDX_CAP_LO: rd_byte = cap_q[7:0];
      irt_pkg::IDX_CAP_HI: rd_byte = cap_q[CNT_W-1:8];
      default: rd_byte = 8'h00;
    endcase
    if (haddr[7:6] != 2'h0)
      rd_byte = 8'h00;
    rdata_d = (hsel && htrans[1] && hready && !hwrite) ? {24'h000000, rd_byte} : rdata_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shared_q <= irt_pkg::SHARED_RST;
      long_q <= irt_pkg::LONG_RST;
      rise_flag_q <= 1'b0;
      fall_flag_q <= 1'b0;
      to_flag_q <= 1'b0;
      rld_q <= irt_pkg::RLD_RST;
      cap_q <= irt_pkg::CAP_RST;
      cnt_q <= irt_pkg::RLD_RST;
      lt_q <= irt_pkg::LT_IDLE;
      lout_q <= 1'b0;
      div_q <= 3'h0;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 4'h0;
      rdata_q <= 32'h00000000;
      sout_q <= 1'b1;
      loutp_q <= 1'b1;
      comb_q <= 1'b0;
      lpin_q <= 1'b0;
      start_q <= 1'b0;
      capirq_q <= 1'b0;
      toirq_q <= 1'b0;
    end
    else
    begin
      shared_q <= shared_d;
      long_q <= long_d;
      rise_flag_q <= rise_flag_d;
      fall_flag_q <= fall_flag_d;
      to_flag_q <= to_flag_d;
      rld_q <= rld_d;
      cap_q <= cap_d;
      cnt_q <= cnt_d;
      lt_q <= lt_d;
      lout_q <= lout_d;
      div_q <= div_d;
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      rdata_q <= rdata_d;
      sout_q <= sout_d;
      loutp_q <= loutp_d;
      comb_q <= comb_d;
      lpin_q <= lpin_d;
      start_q <= start_d;
      capirq_q <= capirq_d;
      toirq_q <= toirq_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign short_timer_start = start_q;
  assign short_timer_output = sout_q;
  assign long_timer_output = loutp_q;
  assign combined_output_pin = comb_q;
  assign long_timer_pin = lpin_q;
  assign capture_irq = capirq_q;
  assign timeout_irq = toirq_q;
endmodule
`default_nettype wire

// ---- test/irt_timer_ctrl_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module irt_timer_ctrl_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic port_combined_data,
  input wire logic port_long_data,
  input wire logic short_timer_running,
  input wire logic short_timer_output,
  input wire logic long_timer_output,
  input wire logic combined_output_pin,
  input wire logic long_timer_pin,
  input wire logic capture_irq,
  input wire logic timeout_irq
);
  // Shadow copies of the two control registers, tracked from bus writes
  logic wr_q;
  logic [7:0] a_q;
  logic [7:0] sh_q;
  logic [7:0] lc_q;
  logic live_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      live_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 8'h00;
      sh_q <= 8'h00;
      lc_q <= 8'h00;
    end
    else
    begin
      // Pins still show reset values one cycle after release
      live_q <= 1'b1;
      wr_q <= hsel && htrans[1] && hready && hwrite;
      a_q <= haddr;
      if (wr_q && a_q == 8'h04)
        sh_q <= hwdata[7:0];
      if (wr_q && a_q == 8'h08)
        lc_q <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_bus_okay;
    hreadyout && !hresp && hrdata[31:8] == 24'h000000;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
  property p_long_port;
    live_q && !lc_q[0] |=> long_timer_pin == $past(port_long_data);
  endproperty
  a_long_port: assert property (p_long_port) else $error("long pin not port data");
  property p_comb_port;
    live_q && !sh_q[7] && !sh_q[6] |=> combined_output_pin == $past(port_combined_data);
  endproperty
  a_comb_port: assert property (p_comb_port) else $error("combined pin not port data");
  property p_force_lo;
    !sh_q[7] && sh_q[3:2] == irt_pkg::SUB_LOW |=> !long_timer_output;
  endproperty
  a_force_lo: assert property (p_force_lo) else $error("long output not forced low");
  property p_force_hi;
    !sh_q[7] && sh_q[3:2] == irt_pkg::SUB_HIGH |=> long_timer_output;
  endproperty
  a_force_hi: assert property (p_force_hi) else $error("long output not forced high");
  property p_short_idle;
    !sh_q[7] && !short_timer_running |=> short_timer_output == !$past(sh_q[1]);
  endproperty
  a_short_idle: assert property (p_short_idle) else $error("idle short output wrong");
  property p_cap_mask;
    capture_irq |-> $past(lc_q[2]);
  endproperty
  a_cap_mask: assert property (p_cap_mask) else $error("capture request while masked");
  property p_to_mask;
    timeout_irq |-> $past(lc_q[1]);
  endproperty
  a_to_mask: assert property (p_to_mask) else $error("time-out request while masked");
  property p_cap_pulse;
    capture_irq |=> !capture_irq;
  endproperty
  a_cap_pulse: assert property (p_cap_pulse) else $error("capture request too long");
  property p_to_pulse;
    timeout_irq |=> !timeout_irq;
  endproperty
  a_to_pulse: assert property (p_to_pulse) else $error("time-out request too long");
endmodule
`default_nettype wire

// ---- test/irt_ir_far.sv ----
`timescale 1ns/100ps
`default_nettype none
module irt_ir_far (
  input wire logic clk,
  input wire logic short_timer_start,
  output logic first_input_pin,
  output logic alternate_input_pin,
  output logic short_timer_running,
  output logic short_timer_level,
  output logic short_timer_done,
  output logic port_combined_data,
  output logic port_long_data
);
  int cnt = 0;
  assign short_timer_running = (cnt > 0);
  assign short_timer_level = cnt[2];
  initial
  begin
    first_input_pin = 1'b0;
    alternate_input_pin = 1'b0;
    short_timer_done = 1'b0;
    port_combined_data = 1'b0;
    port_long_data = 1'b1;
  end
  // Port data changes every cycle so a stale pin cannot pass
  always @(posedge clk)
  begin
    port_combined_data <= ~port_combined_data;
    port_long_data <= port_combined_data;
    short_timer_done <= (cnt == 1);
    if (short_timer_start === 1'b1)
      cnt <= 12;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  task automatic pulse(input logic alt, input int w);
    @(posedge clk);
    if (alt)
      alternate_input_pin <= 1'b1;
    else
      first_input_pin <= 1'b1;
    repeat (w) @(posedge clk);
    alternate_input_pin <= 1'b0;
    first_input_pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- test/irt_timer_ctrl_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module irt_timer_ctrl_test;
  logic clk, rst, hsel, hwrite;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r;
  logic hreadyout, hresp, first_input_pin, alternate_input_pin, short_timer_running;
  logic short_timer_level, short_timer_done, port_combined_data, port_long_data;
  logic short_timer_start, short_timer_output, long_timer_output, combined_output_pin;
  logic long_timer_pin, capture_irq, timeout_irq, e;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int cap_n = 0;
  int st_n = 0;
  int n, c0;
  irt_timer_ctrl u_irt_timer_ctrl (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .first_input_pin(first_input_pin),
    .alternate_input_pin(alternate_input_pin), .short_timer_running(short_timer_running),
    .short_timer_level(short_timer_level), .short_timer_done(short_timer_done),
    .port_combined_data(port_combined_data), .port_long_data(port_long_data),
    .short_timer_start(short_timer_start), .short_timer_output(short_timer_output),
    .long_timer_output(long_timer_output), .combined_output_pin(combined_output_pin),
    .long_timer_pin(long_timer_pin), .capture_irq(capture_irq), .timeout_irq(timeout_irq));
  irt_ir_far u_irt_ir_far (.clk(clk), .short_timer_start(short_timer_start),
    .first_input_pin(first_input_pin), .alternate_input_pin(alternate_input_pin),
    .short_timer_running(short_timer_running), .short_timer_level(short_timer_level),
    .short_timer_done(short_timer_done), .port_combined_data(port_combined_data),
    .port_long_data(port_long_data));
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (capture_irq === 1'b1)
      cap_n <= cap_n + 1;
    if (short_timer_start === 1'b1)
      st_n <= st_n + 1;
    if (cyc == 20000)
    begin
      errors++;
      $display("BAD %0t run hung", $time);
      complete_run();
    end
  end
  task automatic complete_run;
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wt();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    xfer(1'b0, a, 8'h00);
    chk(r, {24'h000000, x});
  endtask
  task automatic wait_to;
    n = 1;
    @(posedge clk);
    while (timeout_irq !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000)
    begin
      errors++;
      $display("BAD %0t no time-out", $time);
      complete_run();
    end
  endtask
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h08, 8'h01);
    // Short timer idle, long output forced, every combine code
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h04, {2'b01, i[2:1], 1'b1, i[0], i[3], 1'b0});
      repeat (3) @(posedge clk);
      case (i[2:1])
        2'h0: e = !i[3] && i[0];
        2'h1: e = !i[3] || i[0];
        2'h2: e = !(!i[3] || i[0]);
        default: e = !(!i[3] && i[0]);
      endcase
      chk({combined_output_pin, long_timer_output, long_timer_pin, short_timer_output},
        {e, i[0], i[0], !i[3]});
    end
    wr(8'h04, 8'h01);
    wr(8'h18, 8'h10);
    wr(8'h1C, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h08, {3'b111, k[1:0], 3'b010});
      repeat (2) @(posedge clk);
      chk(long_timer_output, 1'b1);
      wait_to();
      chk(n + 2 >= (15 << k) && n + 2 <= (17 << k) + 4, 1'b1);
      rd(8'h08, {3'b011, k[1:0], 3'b010});
      chk(long_timer_output, 1'b0);
    end
    wr(8'h08, 8'hA2);
    wait_to();
    wait_to();
    rd(8'h08, 8'hA2);
    wr(8'h08, 8'h20);
    rd(8'h08, 8'h00);
    c0 = st_n;
    wr(8'h04, 8'h45);
    wr(8'h08, 8'hE2);
    wait_to();
    wait_to();
    chk(n < 300, 1'b1);
    repeat (3) @(posedge clk);
    wr(8'h04, 8'h41);
    repeat (40) @(posedge clk);
    chk(st_n - c0, 2);
    rd(8'h08, 8'h62);
    wr(8'h08, 8'h20);
    wr(8'h04, 8'hE0);
    wr(8'h18, 8'hFF);
    wr(8'h1C, 8'hFF);
    c0 = cap_n;
    wr(8'h08, 8'h84);
    u_irt_ir_far.pulse(1'b1, 40);
    repeat (10) @(posedge clk);
    chk(cap_n - c0, 2);
    xfer(1'b0, 8'h20, 8'h00);
    chk(r >= 36 && r <= 46, 1'b1);
    rd(8'h24, 8'h00);
    rd(8'h04, 8'hE3);
    wr(8'h04, 8'hE1);
    rd(8'h04, 8'hE2);
    wr(8'h04, 8'hE2);
    rd(8'h04, 8'hE0);
    wr(8'h08, 8'hC4);
    c0 = cap_n;
    u_irt_ir_far.pulse(1'b1, 40);
    repeat (10) @(posedge clk);
    chk(cap_n - c0, 1);
    wr(8'h04, 8'hE3);
    u_irt_ir_far.pulse(1'b0, 20);
    repeat (5) @(posedge clk);
    rd(8'h04, 8'hE0);
    for (int f = 1; f < 3; f++)
    begin
      wr(8'h04, {4'hD, f[1:0], 2'b11});
      u_irt_ir_far.pulse(1'b1, 4 * f - 2);
      repeat (14) @(posedge clk);
      rd(8'h04, {4'hD, f[1:0], 2'b00});
      u_irt_ir_far.pulse(1'b1, 4 * f + 4);
      repeat (14) @(posedge clk);
      rd(8'h04, {4'hD, f[1:0], 2'b10});
    end
    // Falling edges only, capture request masked
    wr(8'h04, 8'hC3);
    wr(8'h08, 8'h80);
    c0 = cap_n;
    u_irt_ir_far.pulse(1'b1, 3);
    repeat (5) @(posedge clk);
    chk(cap_n - c0, 0);
    rd(8'h04, 8'hC1);
    complete_run();
  end
endmodule
bind irt_timer_ctrl irt_timer_ctrl_asserts u_irt_timer_ctrl_asserts (.clk(clk), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .port_combined_data(port_combined_data), .port_long_data(port_long_data),
  .short_timer_running(short_timer_running), .short_timer_output(short_timer_output),
  .long_timer_output(long_timer_output), .combined_output_pin(combined_output_pin),
  .long_timer_pin(long_timer_pin), .capture_irq(capture_irq), .timeout_irq(timeout_irq));
`default_nettype wire
